// ---- hw/dma_fifo_test_control.sv ----
// Purpose: DMA FIFO test, control and step register bank behind an APB slave
// Assumes: Single clock mclk at 100 MHz, synchronous active high reset
// Notes:   Core-side event inputs come from logic on the same clock
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps

// Overview of operation
// - Status bit reads one when acknowledge inactive
// - Upper nibble shows revision identifier nibble
// - Flush drains FIFO; software clears bit
// - Byte empty/full flags readable during flush
// - Clear bit resets pointers, then self-clears
// - Fetch pin only during opcode when set
// - Write-invalidate enable selects invalidate commands
// - Hold register stores call, restores return
// - Hold register kept across memory moves
// - Ten-bit offset counter split across registers
// - Burst disable forces single back-to-back cycles
// - High-impedance test floats all pins
// - SCSI data float floats data, parity
// - Shadow mode redirects hold, structure accesses
// - Master parity enable gates parity errors
// - Lane enable picks byte lane explicitly
// - Without enable, lane from pointer, count
// - Address step increments pointer, self-clears
// - Count step decrements counter, self-clears
// - Size bit selects 88 or 536 depth
// - Master bit decides direction set or clear
// - Direction asserted means SCSI toward host
module dma_fifo_test_control
  import dma_test_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1  // Arbitrary revision nibble
) (
  input  wire logic        mclk,              // System clock
  input  wire logic        sys_rst,           // Synchronous reset
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB access phase
  input  wire logic        pwrite,            // APB direction
  input  wire logic [11:0] paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic      [31:0] prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB error
  input  wire logic        data_ack_internal, // Active low acknowledge
  input  wire logic [3:0]  fifo_byte_empty,   // Bottom lane empty flags
  input  wire logic [3:0]  fifo_byte_full,    // Top lane full flags
  input  wire logic        flush_done,        // FIFO drain finished
  input  wire logic        clear_done,        // Pointers cleared
  input  wire logic        call_exec,         // Call instruction executes
  input  wire logic        return_exec,       // Return instruction executes
  input  wire logic [31:0] call_return_addr,  // Address saved by a call
  input  wire logic        mem_move_active,   // Memory-to-memory move running
  input  wire logic [31:0] struct_addr_in,    // New structure address
  input  wire logic        struct_addr_load,  // Load structure address
  input  wire logic        core_byte_moved,   // One byte passed cores
  input  wire logic        fetch_cycle,       // Instruction fetch bus cycle
  input  wire logic        fetch_opcode,      // Opcode part of the fetch
  input  wire logic        master_parity_err, // Parity fault seen as master
  input  wire logic        bus_write_cycle,   // Master write due now
  output logic             flush_req,         // Drain FIFO to memory
  output logic             fifo_clear,        // Clear FIFO pointers
  output logic             fetch_n,           // Active low fetch pin
  output logic             mwi_cmd,           // Use write and invalidate
  output logic             single_cycles,     // Back-to-back single cycles
  output logic             all_pins_float,    // Float every pin
  output logic             scsi_data_float,   // Float data and parity lines
  output logic             parity_irq,        // Master parity error event
  output logic [1:0]       fifo_lane,         // Active FIFO byte lane
  output logic             dma_write_direction, // High: SCSI to host
  output logic             fifo_large,        // 536 byte mode
  output logic [31:0]      ip_load,           // Instruction pointer reload
  output logic             ip_load_en,        // Reload strobe
  output logic [31:0]      next_address_pointer, // Address pointer
  output logic [23:0]      byte_counter       // Byte counter
);

  // Decoded index: printed offsets are indices, address is four times that
  logic [7:0]  idx;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [7:0]  ctrl_reg;           // Test mode control
  logic [3:0]  ctrl_low_reg;       // flush, clear, fetch mode, invalidate
  logic [7:0]  step_reg;           // Step, size, master, direction
  logic [9:0]  offset_reg;         // Byte offset counter
  logic [31:0] hold_reg;           // Return address hold
  logic [31:0] shadow_hold_reg;    // Shadow hold copy
  logic [31:0] struct_reg;         // Data structure address
  logic [31:0] shadow_struct_reg;  // Shadow structure copy
  logic [31:0] rd_next;            // Read mux
  logic [2:0]  step_amt;           // Bytes to the next word boundary
  logic        flush_finished_reg; // Drain reported, until bit cleared

  assign idx   = paddr[9:2];
  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign hit   = (idx == IDX_REV_FIFO_CTRL) || (idx == IDX_RET_ADDR_HOLD) ||
                 (idx == IDX_FIFO_BYTE_OFS) || (idx == IDX_FIFO_TEST_MODE) ||
                 (idx == IDX_DMA_STEP_SIZE) || (idx == IDX_DMA_STATUS) ||
                 (idx == IDX_NEXT_ADDR) || (idx == IDX_BYTE_COUNT) ||
                 (idx == IDX_STRUCT_ADDR);

  // Step is the distance to the next word boundary, capped by the count
  always_comb begin
    step_amt = 3'd4 - {1'b0, next_address_pointer[1:0]};
    if (byte_counter < {21'h0, step_amt}) begin
      step_amt = byte_counter[2:0];
    end
  end

  // APB ready: registered from setup, so no wait state; read data is registered in setup
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00 && hit);
    end
  end

  // Read mux, registered in the setup cycle
  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (idx)
      IDX_REV_FIFO_CTRL:  rd_next = {24'h0, REVISION, ctrl_low_reg};
      IDX_RET_ADDR_HOLD:  rd_next = ctrl_reg[SHADOW_TEST_MODE_BIT] ? shadow_hold_reg : hold_reg;
      IDX_FIFO_BYTE_OFS:  rd_next = {24'h0, offset_reg[7:0]};
      IDX_FIFO_TEST_MODE: rd_next = {24'h0, ctrl_reg};
      IDX_DMA_STEP_SIZE:  rd_next = {24'h0, step_reg[7:2], offset_reg[9:8]};
      // Flags live beside acknowledge so polling works during flush
      IDX_DMA_STATUS:     rd_next = {23'h0, fifo_byte_empty, fifo_byte_full, data_ack_internal};
      IDX_NEXT_ADDR:      rd_next = next_address_pointer;
      IDX_BYTE_COUNT:     rd_next = {8'h0, byte_counter};
      IDX_STRUCT_ADDR:    rd_next = ctrl_reg[SHADOW_TEST_MODE_BIT] ? shadow_struct_reg : struct_reg;
      default:            rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= rd_next;
    end
  end

  // Flush, clear, fetch mode and invalidate enable
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_low_reg <= CTRL_LOW_RST;
    end else begin
      if (wr_en && idx == IDX_REV_FIFO_CTRL) begin
        ctrl_low_reg <= pwdata[3:0];
      end
      // Clear bit drops itself once pointers are gone; a new set wins
      if (clear_done && !(wr_en && idx == IDX_REV_FIFO_CTRL && pwdata[CLEAR_BIT])) begin
        ctrl_low_reg[CLEAR_BIT] <= 1'b0;
      end
    end
  end

  // Test mode control register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_reg <= TEST_MODE_RST;
    end else if (wr_en && idx == IDX_FIFO_TEST_MODE) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // Step control: size and master stored, direction set or cleared by master
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      step_reg <= 8'h00;
    end else if (wr_en && idx == IDX_DMA_STEP_SIZE) begin
      step_reg[ADDR_STEP] <= pwdata[ADDR_STEP];
      step_reg[CNT_STEP]  <= pwdata[CNT_STEP];
      step_reg[FSIZE_BIT] <= pwdata[FSIZE_BIT];
      step_reg[SET_RESET_MASTER_BIT]  <= pwdata[SET_RESET_MASTER_BIT];
      step_reg[2]         <= pwdata[2];
      // Writing one to direction acts per the stored master bit
      if (pwdata[TRANSFER_DIRECTION_BIT_BIT]) begin
        step_reg[TRANSFER_DIRECTION_BIT_BIT] <= step_reg[SET_RESET_MASTER_BIT];
      end
    end else begin
      step_reg[ADDR_STEP] <= 1'b0;
      step_reg[CNT_STEP]  <= 1'b0;
    end
  end

  // Address pointer and byte counter, stepped manually
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      next_address_pointer <= ADDR_RST;
      byte_counter         <= COUNT_RST;
    end else begin
      if (wr_en && idx == IDX_NEXT_ADDR) begin
        next_address_pointer <= pwdata;
      end else if (step_reg[ADDR_STEP]) begin
        next_address_pointer <= next_address_pointer + {29'h0, step_amt};
      end
      if (wr_en && idx == IDX_BYTE_COUNT) begin
        byte_counter <= pwdata[23:0];
      end else if (step_reg[CNT_STEP]) begin
        byte_counter <= byte_counter - {21'h0, step_amt};
      end
    end
  end

  // Byte offset counter counts bytes between cores, wraps per size
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      offset_reg <= OFS_RST;
    end else if (wr_en && idx == IDX_FIFO_BYTE_OFS) begin
      offset_reg[7:0] <= pwdata[7:0];
    end else if (ctrl_low_reg[CLEAR_BIT]) begin
      offset_reg <= OFS_RST;
    end else if (core_byte_moved) begin
      offset_reg <= (offset_reg + 10'd1) & (step_reg[FSIZE_BIT] ? MASK_LARGE : MASK_SMALL);
    end
  end

  // Hold register and its shadow; moves use the shadow so the hold survives
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hold_reg        <= ADDR_RST;
      shadow_hold_reg <= ADDR_RST;
    end else begin
      if (wr_en && idx == IDX_RET_ADDR_HOLD) begin
        if (ctrl_reg[SHADOW_TEST_MODE_BIT]) begin
          shadow_hold_reg <= pwdata;
        end else begin
          hold_reg <= pwdata;
        end
      end else if (call_exec) begin
        if (mem_move_active) begin
          shadow_hold_reg <= call_return_addr;
        end else begin
          hold_reg <= call_return_addr;
        end
      end
    end
  end

  // Structure address and its shadow
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      struct_reg        <= ADDR_RST;
      shadow_struct_reg <= ADDR_RST;
    end else if (wr_en && idx == IDX_STRUCT_ADDR) begin
      if (ctrl_reg[SHADOW_TEST_MODE_BIT]) begin
        shadow_struct_reg <= pwdata;
      end else begin
        struct_reg <= pwdata;
      end
    end else if (struct_addr_load) begin
      if (mem_move_active) begin
        shadow_struct_reg <= struct_addr_in;
      end else begin
        struct_reg <= struct_addr_in;
      end
    end
  end

  // Drain finished marker: a held flush bit must not start a second drain
  // once the core has reported completion; clearing the bit rearms it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flush_finished_reg <= 1'b0;
    end else if (flush_done) begin
      flush_finished_reg <= 1'b1;
    end else if (!ctrl_low_reg[FLUSH_BIT]) begin
      flush_finished_reg <= 1'b0;
    end
  end

  // Registered control outputs toward the core and pads
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flush_req           <= 1'b0;
      fifo_clear          <= 1'b0;
      fetch_n             <= 1'b1;
      mwi_cmd             <= 1'b0;
      single_cycles       <= 1'b0;
      all_pins_float      <= 1'b0;
      scsi_data_float     <= 1'b0;
      parity_irq          <= 1'b0;
      fifo_lane           <= 2'b00;
      dma_write_direction <= 1'b0;
      fifo_large          <= 1'b0;
      ip_load             <= ADDR_RST;
      ip_load_en          <= 1'b0;
    end else begin
      // Flush request holds until the core reports the drain done or software clears the bit
      flush_req  <= ctrl_low_reg[FLUSH_BIT] && !flush_done && !flush_finished_reg;
      fifo_clear <= ctrl_low_reg[CLEAR_BIT];
      // Fetch mode limits the pin to the opcode part
      fetch_n <= !(fetch_cycle && (!ctrl_low_reg[FETCH_BIT] || fetch_opcode));
      mwi_cmd <= ctrl_low_reg[WRITE_INVALIDATE_ENABLE_BIT] && bus_write_cycle;
      single_cycles   <= ctrl_reg[BURST_DISABLE_BIT_BIT];
      all_pins_float  <= ctrl_reg[ALL_PINS_FLOAT_BIT];
      scsi_data_float <= ctrl_reg[ZSD_BIT] || ctrl_reg[ALL_PINS_FLOAT_BIT];
      parity_irq      <= ctrl_reg[MASTER_PARITY_ENABLE_BIT] && master_parity_err;
      // Explicit lane only in test mode, otherwise from pointer plus count
      fifo_lane <= ctrl_reg[LANE_EN] ? ctrl_reg[1:0] :
                   (next_address_pointer[1:0] + byte_counter[1:0]);
      dma_write_direction <= step_reg[TRANSFER_DIRECTION_BIT_BIT];
      fifo_large          <= step_reg[FSIZE_BIT];
      ip_load_en          <= return_exec;
      if (return_exec) begin
        ip_load <= hold_reg;
      end
    end
  end

  // Assertions
  chk_clear_self_drop: assert property (@(posedge mclk) disable iff (sys_rst)
    clear_done && !wr_en |=> !ctrl_low_reg[CLEAR_BIT])
    else $error("clear bit did not drop");
  chk_addr_step_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    step_reg[ADDR_STEP] && !wr_en |=> !step_reg[ADDR_STEP])
    else $error("address step stuck");
  chk_cnt_step_dec: assert property (@(posedge mclk) disable iff (sys_rst)
    step_reg[CNT_STEP] && !(wr_en && idx == IDX_BYTE_COUNT) |=>
      byte_counter == $past(byte_counter) - {21'h0, $past(step_amt)})
    else $error("count step did not decrement");
  chk_ret_reload: assert property (@(posedge mclk) disable iff (sys_rst)
    return_exec |=> ip_load_en && ip_load == $past(hold_reg))
    else $error("return did not reload");
  chk_float_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_reg[ALL_PINS_FLOAT_BIT] |=> all_pins_float && scsi_data_float)
    else $error("pins not floated");
  chk_lane_select: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_reg[LANE_EN] |=> fifo_lane == $past(ctrl_reg[1:0]))
    else $error("lane mismatch");
  chk_parity_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_reg[MASTER_PARITY_ENABLE_BIT] |=> !parity_irq)
    else $error("parity error not gated");
  chk_fetch_mode: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_low_reg[FETCH_BIT] && fetch_cycle && !fetch_opcode |=> fetch_n)
    else $error("fetch pin active outside opcode");
  chk_move_keeps_hold: assert property (@(posedge mclk) disable iff (sys_rst)
    mem_move_active && !wr_en |=> $stable(hold_reg))
    else $error("hold changed during move");
  // Drain marker and mode bits must reach their registered outputs one cycle later
  chk_flush_once: assert property (@(posedge mclk) disable iff (sys_rst)
    flush_finished_reg |=> !flush_req)
    else $error("flush restarted");
  chk_size_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    step_reg[FSIZE_BIT] |=> fifo_large)
    else $error("size mode not applied");
  chk_dir_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    step_reg[TRANSFER_DIRECTION_BIT_BIT] |=> dma_write_direction)
    else $error("direction not applied");
  chk_burst_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_reg[BURST_DISABLE_BIT_BIT] |=> single_cycles)
    else $error("burst disable not applied");
  chk_data_float: assert property (@(posedge mclk) disable iff (sys_rst)
    ctrl_reg[ZSD_BIT] |=> scsi_data_float)
    else $error("data lines not floated");
  chk_invalidate_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctrl_low_reg[WRITE_INVALIDATE_ENABLE_BIT] |=> !mwi_cmd)
    else $error("invalidate used while disabled");
  // Main scenarios: drain, manual steps, call and return, float, explicit lane
  cov_flush: cover property (@(posedge mclk) ctrl_low_reg[FLUSH_BIT] ##1 flush_done);
  cov_step: cover property (@(posedge mclk) step_reg[ADDR_STEP] && step_reg[CNT_STEP]);
  cov_call_ret: cover property (@(posedge mclk) call_exec ##[1:20] return_exec);
  cov_float: cover property (@(posedge mclk) ctrl_reg[ALL_PINS_FLOAT_BIT] ##1 all_pins_float);
  cov_lane: cover property (@(posedge mclk) ctrl_reg[LANE_EN] ##1 fifo_lane == 2'b11);

endmodule // dma_fifo_test_control

// ---- hw/dma_test_pkg.sv ----
// Purpose: Constants for the DMA FIFO test and control register bank
// Assumes: APB byte addresses derived from printed register indices
// Notes:   Printed offsets are not word aligned, so byte address is index times four
package dma_test_pkg;
  // Printed register indices
  localparam logic [7:0] IDX_REV_FIFO_CTRL   = 8'h1b;
  localparam logic [7:0] IDX_RET_ADDR_HOLD   = 8'h1c;
  localparam logic [7:0] IDX_FIFO_BYTE_OFS   = 8'h20;
  localparam logic [7:0] IDX_FIFO_TEST_MODE  = 8'h21;
  localparam logic [7:0] IDX_DMA_STEP_SIZE   = 8'h22;
  // Own registers: status, address pointer, byte counter, structure address
  localparam logic [7:0] IDX_DMA_STATUS      = 8'h40;
  localparam logic [7:0] IDX_NEXT_ADDR       = 8'h41;
  localparam logic [7:0] IDX_BYTE_COUNT      = 8'h42;
  localparam logic [7:0] IDX_STRUCT_ADDR     = 8'h43;
  // Field positions in revision_fifo_control
  localparam int REV_LSB   = 4;
  localparam int FLUSH_BIT = 3;
  localparam int CLEAR_BIT = 2;
  localparam int FETCH_BIT = 1;
  localparam int WRITE_INVALIDATE_ENABLE_BIT  = 0;
  // Field positions in fifo_test_mode_control
  localparam int BURST_DISABLE_BIT_BIT  = 7;
  localparam int ALL_PINS_FLOAT_BIT  = 6;
  localparam int ZSD_BIT   = 5;
  localparam int SHADOW_TEST_MODE_BIT  = 4;
  localparam int MASTER_PARITY_ENABLE_BIT  = 3;
  localparam int LANE_EN   = 2;
  // Field positions in dma_step_size_control
  localparam int ADDR_STEP = 7;
  localparam int CNT_STEP  = 6;
  localparam int FSIZE_BIT = 5;
  localparam int SET_RESET_MASTER_BIT  = 4;
  localparam int TRANSFER_DIRECTION_BIT_BIT  = 3;
  // Reset values
  localparam logic [7:0]  TEST_MODE_RST = 8'h00;
  localparam logic [3:0]  CTRL_LOW_RST  = 4'h0;
  localparam logic [9:0]  OFS_RST       = 10'h000;
  localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
  localparam logic [23:0] COUNT_RST     = 24'h00_0000;
  // FIFO depths and residue masks
  localparam int          FIFO_SMALL    = 88;
  localparam int          FIFO_LARGE    = 536;
  localparam logic [9:0]  MASK_SMALL    = 10'h07f;
  localparam logic [9:0]  MASK_LARGE    = 10'h3ff;
endpackage

// ---- verification/core_side_model.sv ----
// Purpose: Core-side partner that answers flush and clear requests
// Assumes: Same clock and reset as the register bank
// Notes:   LAT sets how slowly the drain and pointer clear finish
`timescale 1ns/1ps
module core_side_model #(
  parameter int LAT = 8  // One less than the cycles from request to done pulse
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic flush_req,
  input  wire logic fifo_clear,
  output logic      flush_done,
  output logic      clear_done
);
  int f_cnt;  // Drain progress while flush is requested
  int c_cnt;  // Clear progress while clear is requested

  // One done pulse per request; a held request never gets a second pulse
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      f_cnt      <= 0;
      c_cnt      <= 0;
      flush_done <= 1'b0;
      clear_done <= 1'b0;
    end else begin
      f_cnt      <= flush_req ? f_cnt + 1 : 0;
      c_cnt      <= fifo_clear ? c_cnt + 1 : 0;
      flush_done <= flush_req && (f_cnt == LAT);
      clear_done <= fifo_clear && (c_cnt == LAT);
    end
  end
endmodule // core_side_model

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the DMA FIFO test register bank
// Assumes: APB master with zero wait states tolerated but not assumed
// Notes:   Pulses from the bank are caught by monitors, levels sampled late
`timescale 1ns/1ps
module testbench;
  import dma_test_pkg::*;
  logic        mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, call_return_addr = 32'h0000_0000, rd_v;
  logic        pready, pslverr, data_ack_internal = 1'b1, flush_done, clear_done, err_v;
  logic [3:0]  fifo_byte_empty = 4'hf, fifo_byte_full = 4'h0;
  logic        call_exec = 1'b0, return_exec = 1'b0, mem_move_active = 1'b0, core_byte_moved = 1'b0;
  logic        fetch_cycle = 1'b0, fetch_opcode = 1'b0, master_parity_err = 1'b0, bus_write_cycle = 1'b0;
  logic        flush_req, fifo_clear, fetch_n, mwi_cmd, single_cycles, all_pins_float, scsi_data_float;
  logic        parity_irq, dma_write_direction, fifo_large, ip_load_en;
  logic [1:0]  fifo_lane;
  logic [31:0] ip_load, next_address_pointer, ip_seen;
  logic [23:0] byte_counter;
  int          fail_count = 0, samples_checked = 0, cycles = 0, par_seen = 0;

  dma_fifo_test_control dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_ack_internal(data_ack_internal), .fifo_byte_empty(fifo_byte_empty), .fifo_byte_full(fifo_byte_full),
    .flush_done(flush_done), .clear_done(clear_done), .call_exec(call_exec), .return_exec(return_exec),
    .call_return_addr(call_return_addr), .mem_move_active(mem_move_active), .struct_addr_in(call_return_addr),
    .struct_addr_load(call_exec), .core_byte_moved(core_byte_moved), .fetch_cycle(fetch_cycle),
    .fetch_opcode(fetch_opcode), .master_parity_err(master_parity_err), .bus_write_cycle(bus_write_cycle),
    .flush_req(flush_req), .fifo_clear(fifo_clear), .fetch_n(fetch_n), .mwi_cmd(mwi_cmd),
    .single_cycles(single_cycles), .all_pins_float(all_pins_float), .scsi_data_float(scsi_data_float),
    .parity_irq(parity_irq), .fifo_lane(fifo_lane), .dma_write_direction(dma_write_direction),
    .fifo_large(fifo_large), .ip_load(ip_load), .ip_load_en(ip_load_en),
    .next_address_pointer(next_address_pointer), .byte_counter(byte_counter));

  core_side_model core (.mclk(mclk), .sys_rst(sys_rst), .flush_req(flush_req), .fifo_clear(fifo_clear),
    .flush_done(flush_done), .clear_done(clear_done));

  always #5 mclk = ~mclk;

  // Hang guard and capture of one-cycle pulses from the bank
  always @(posedge mclk) begin
    cycles++;
    if (parity_irq === 1'b1) par_seen++;
    if (ip_load_en === 1'b1) ip_seen = ip_load;
    if (cycles == 5000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd_v = prdata;
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(what, exp, rd_v);
  endtask

  task automatic settle();
    repeat (2) @(posedge mclk);
  endtask

  task automatic t_reset_map();
    rd_chk("revision", IDX_REV_FIFO_CTRL, 32'h0000_0010);
    rd_chk("test mode", IDX_FIFO_TEST_MODE, 32'h0000_0000);
    rd_chk("step reg", IDX_DMA_STEP_SIZE, 32'h0000_0000);
    chk("fetch idle", 32'h1, {31'h0, fetch_n});
    rd_chk("unmapped", 8'hff, 32'h0000_0000);
    chk("unmapped err", 32'h1, {31'h0, err_v});
    $display("test reset_map done");
  endtask

  task automatic t_status_flush();
    fifo_byte_empty <= 4'ha;
    fifo_byte_full  <= 4'h5;
    rd_chk("status ack off", IDX_DMA_STATUS, 32'h0000_014b);
    data_ack_internal <= 1'b0;
    apb(1'b1, IDX_REV_FIFO_CTRL, 32'h0000_0008);
    rd_chk("status in flush", IDX_DMA_STATUS, 32'h0000_014a);
    chk("flush req", 32'h1, {31'h0, flush_req});
    for (int i = 0; i < 20 && flush_req === 1'b1; i++) @(posedge mclk);
    rd_chk("flush bit kept", IDX_REV_FIFO_CTRL, 32'h0000_0018);
    chk("flush stays done", 32'h0, {31'h0, flush_req});
    apb(1'b1, IDX_REV_FIFO_CTRL, 32'h0000_0000);
    apb(1'b1, IDX_REV_FIFO_CTRL, 32'h0000_0004);
    settle();
    chk("clear req", 32'h1, {31'h0, fifo_clear});
    for (int i = 0; i < 20 && fifo_clear === 1'b1; i++) @(posedge mclk);
    rd_chk("clear self", IDX_REV_FIFO_CTRL, 32'h0000_0010);
    $display("test status_flush done");
  endtask

  task automatic t_modes();
    apb(1'b1, IDX_FIFO_TEST_MODE, 32'h0000_00c7);
    settle();
    chk("float lane", 32'h1f, {27'h0, single_cycles, all_pins_float, scsi_data_float, fifo_lane});
    apb(1'b1, IDX_FIFO_TEST_MODE, 32'h0000_0025);
    settle();
    chk("data float", 32'h05, {27'h0, single_cycles, all_pins_float, scsi_data_float, fifo_lane});
    rd_chk("mode back", IDX_FIFO_TEST_MODE, 32'h0000_0025);
    master_parity_err <= 1'b1;
    settle();
    master_parity_err <= 1'b0;
    settle();
    chk("parity off", 32'h0, par_seen);
    apb(1'b1, IDX_FIFO_TEST_MODE, 32'h0000_0008);
    master_parity_err <= 1'b1;
    @(posedge mclk);
    master_parity_err <= 1'b0;
    settle();
    chk("parity on", 32'h1, par_seen);
    $display("test modes done");
  endtask

  task automatic t_pins();
    bus_write_cycle <= 1'b1;
    fetch_cycle     <= 1'b1;
    settle();
    chk("plain fetch", 32'h0, {30'h0, fetch_n, mwi_cmd});
    apb(1'b1, IDX_REV_FIFO_CTRL, 32'h0000_0003);
    settle();
    chk("fetch data part", 32'h3, {30'h0, fetch_n, mwi_cmd});
    fetch_opcode <= 1'b1;
    settle();
    chk("fetch opcode", 32'h1, {30'h0, fetch_n, mwi_cmd});
    $display("test pins done");
  endtask

  task automatic t_hold();
    apb(1'b1, IDX_RET_ADDR_HOLD, 32'h1234_5678);
    mem_move_active  <= 1'b1;
    call_return_addr <= 32'h0000_0abc;
    call_exec        <= 1'b1;
    @(posedge mclk);
    call_exec        <= 1'b0;
    mem_move_active  <= 1'b0;
    rd_chk("hold kept", IDX_RET_ADDR_HOLD, 32'h1234_5678);
    apb(1'b1, IDX_FIFO_TEST_MODE, 32'h0000_0010);
    rd_chk("shadow hold", IDX_RET_ADDR_HOLD, 32'h0000_0abc);
    rd_chk("shadow struct", IDX_STRUCT_ADDR, 32'h0000_0abc);
    apb(1'b1, IDX_FIFO_TEST_MODE, 32'h0000_0000);
    call_return_addr <= 32'h0000_0def;
    call_exec        <= 1'b1;
    @(posedge mclk);
    call_exec   <= 1'b0;
    return_exec <= 1'b1;
    @(posedge mclk);
    return_exec <= 1'b0;
    settle();
    chk("return load", 32'h0000_0def, ip_seen);
    rd_chk("struct addr", IDX_STRUCT_ADDR, 32'h0000_0def);
    repeat (5) begin
      core_byte_moved <= 1'b1;
      @(posedge mclk);
      core_byte_moved <= 1'b0;
      @(posedge mclk);
    end
    rd_chk("offset low", IDX_FIFO_BYTE_OFS, 32'h0000_0005);
    $display("test hold done");
  endtask

  task automatic t_dir_step();
    apb(1'b1, IDX_DMA_STEP_SIZE, 32'h0000_0030);
    apb(1'b1, IDX_DMA_STEP_SIZE, 32'h0000_0038);
    settle();
    chk("dir set", 32'h3, {30'h0, dma_write_direction, fifo_large});
    rd_chk("step back", IDX_DMA_STEP_SIZE, 32'h0000_0038);
    apb(1'b1, IDX_DMA_STEP_SIZE, 32'h0000_0020);
    apb(1'b1, IDX_DMA_STEP_SIZE, 32'h0000_0028);
    settle();
    chk("dir clear", 32'h1, {30'h0, dma_write_direction, fifo_large});
    apb(1'b1, IDX_NEXT_ADDR, 32'h0000_1001);
    apb(1'b1, IDX_BYTE_COUNT, 32'h0000_0010);
    apb(1'b1, IDX_DMA_STEP_SIZE, 32'h0000_00a0);
    settle();
    chk("addr step", 32'h0000_1004, next_address_pointer);
    rd_chk("addr step self", IDX_DMA_STEP_SIZE, 32'h0000_0020);
    apb(1'b1, IDX_DMA_STEP_SIZE, 32'h0000_0060);
    settle();
    chk("count step", 32'h0000_000c, {8'h00, byte_counter});
    chk("residue", 32'h0000_03f9, {22'h0, (10'd5 - byte_counter[9:0]) & MASK_LARGE});
    $display("test dir_step done");
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    t_reset_map();
    t_status_flush();
    t_modes();
    t_pins();
    t_hold();
    t_dir_step();
    tally_and_finish();
  end
endmodule // testbench
